/* File: hdl/tx_modulator_data_delay.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// flip-flop fifo
// ------------------------------------------------------------
module fifo_buf
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  // handshakes are combinational from the fill count
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb
  begin
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // storage carries no reset: only the pointers define content
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule
// ------------------------------------------------------------
// modulator data gating around the transmit strobe
// ------------------------------------------------------------
module tx_modulator_data_delay
  import tx_delay_pkg::*;
#(
  parameter int TICK_CYCLES = EIGHTH_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        serial_bit_clock,
  input  wire logic        serial_data,
  input  wire logic        serial_data_en,
  output logic             serial_data_ready,
  input  wire logic        transmit_strobe,
  input  wire logic        idle_modulator_bit,
  input  wire logic        ramp_control_mode,
  input  wire logic        serial_mode,
  input  wire logic        clock_master,
  input  wire logic        reg_wr_en,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [17:0] reg_wr_data,
  output logic      [17:0] reg_rd_data,
  output var mod_out_t     mod_out
);
  typedef enum logic [2:0] {
    IDLE_S, START_S, RUN_S, DRAIN_S, RESUME_S, HOLD_S
  } gate_state_t;
  // ------------------------------------------------------------
  // register
  // ------------------------------------------------------------
  delay_cfg_t tx_data_delay_reg, tx_data_delay_next;
  always_comb
  begin
    tx_data_delay_next = tx_data_delay_reg;
    if (reg_wr_en && reg_addr == DELAY_REG_ADDR)
      tx_data_delay_next = reg_wr_data;
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
      tx_data_delay_reg <= DELAY_REG_RESET;
    else
      tx_data_delay_reg <= tx_data_delay_next;
  end
  // unmapped addresses read as zero
  assign reg_rd_data = (reg_addr == DELAY_REG_ADDR) ? tx_data_delay_reg : '0;
  // ------------------------------------------------------------
  // link domain: bit capture on the serial bit clock
  // ------------------------------------------------------------
  logic link_rst_meta, link_rst_reg, link_rdy_meta, link_rdy_reg;
  logic link_bit_reg, link_bit_next, link_tog_reg, link_tog_next;
  logic fifo_in_ready;
  // local reset release for the link side; no async path needed
  always_ff @(posedge serial_bit_clock)
  begin
    link_rst_meta <= rstn;
    link_rst_reg  <= link_rst_meta;
    link_rdy_meta <= fifo_in_ready;
    link_rdy_reg  <= link_rdy_meta;
  end
  // back-pressure reaches the source through this level
  assign serial_data_ready = link_rdy_reg && link_rst_reg;
  always_comb
  begin
    link_bit_next = link_bit_reg;
    link_tog_next = link_tog_reg;
    if (serial_data_en && serial_data_ready)
    begin
      link_bit_next = serial_data;
      link_tog_next = !link_tog_reg;
    end
  end
  always_ff @(posedge serial_bit_clock)
  begin
    if (!link_rst_reg)
    begin
      link_bit_reg <= 1'b0;
      link_tog_reg <= 1'b0;
    end
    else
    begin
      link_bit_reg <= link_bit_next;
      link_tog_reg <= link_tog_next;
    end
  end
  // ------------------------------------------------------------
  // crossings into clk: toggle event plus strobe level
  // ------------------------------------------------------------
  logic tog_meta, tog_sync, tog_last, stb_meta, stb_sync, stb_last;
  logic push_valid, stb_rise, stb_fall, fifo_bit, fifo_valid, fifo_pop;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_last <= 1'b0;
      stb_meta <= 1'b0;
      stb_sync <= 1'b0;
      stb_last <= 1'b0;
    end
    else
    begin
      tog_meta <= link_tog_reg;
      tog_sync <= tog_meta;
      tog_last <= tog_sync;
      stb_meta <= transmit_strobe;
      stb_sync <= stb_meta;
      stb_last <= stb_sync;
    end
  end
  // link bit is stable for a whole link period after its toggle
  assign push_valid = tog_sync ^ tog_last;
  assign stb_rise   = stb_sync && !stb_last;
  assign stb_fall   = !stb_sync && stb_last;
  fifo_buf #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (link_bit_reg),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_bit),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // ------------------------------------------------------------
  // eighth-symbol tick and symbol phase
  // ------------------------------------------------------------
  logic [15:0] div_reg, div_next;
  logic [2:0]  phase_reg, phase_next;
  logic        tick, sym_start, sym_end;
  assign tick      = (div_reg == 16'(TICK_CYCLES - 1));
  assign sym_end   = tick && (phase_reg == 3'h7);
  assign sym_start = tick && (phase_reg == 3'h0);
  always_comb
  begin
    div_next   = tick ? 16'h0000 : div_reg + 16'h0001;
    phase_next = tick ? phase_reg + 3'h1 : phase_reg;
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_reg   <= 16'h0000;
      phase_reg <= 3'h0;
    end
    else
    begin
      div_reg   <= div_next;
      phase_reg <= phase_next;
    end
  end
  // ------------------------------------------------------------
  // gating state machine with delay down-counter
  // ------------------------------------------------------------
  gate_state_t state_reg, state_next;
  logic [8:0]  cnt_reg, cnt_next, start_eff;
  logic        data_gate;
  // in serial mode, an external bit clock makes the start delay void
  assign start_eff = (serial_mode && !clock_master) ? 9'h000
                                          : tx_data_delay_reg.start_delay;
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      IDLE_S:
        if (stb_rise)
        begin
          cnt_next   = start_eff;
          state_next = START_S;
        end
      START_S, RESUME_S:
        if (cnt_reg == 9'h000)
          state_next = RUN_S;
        else if (tick)
          cnt_next = cnt_reg - 9'h001;
      RUN_S:
        if (stb_fall)
          state_next = DRAIN_S;
      DRAIN_S:
        if (sym_end)
        begin
          if (ramp_control_mode)
            state_next = HOLD_S;
          else
          begin
            cnt_next   = tx_data_delay_reg.resume_delay;
            state_next = RESUME_S;
          end
        end
      HOLD_S:
        if (stb_rise)
        begin
          cnt_next   = tx_data_delay_reg.resume_delay;
          state_next = RESUME_S;
        end
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= IDLE_S;
      cnt_reg   <= 9'h000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end
  // ------------------------------------------------------------
  // modulator bit, chosen once per symbol
  // ------------------------------------------------------------
  mod_out_t mod_out_reg, mod_out_next;
  // drain keeps the symbol already running; new symbols need run
  assign data_gate = (state_reg == RUN_S);
  assign fifo_pop  = sym_start && data_gate && fifo_valid;
  always_comb
  begin
    mod_out_next            = mod_out_reg;
    mod_out_next.sym_strobe = sym_start;
    if (sym_start)
      mod_out_next.bit_value = fifo_pop ? fifo_bit
                                        : idle_modulator_bit;
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
      mod_out_reg <= '0;
    else
      mod_out_reg <= mod_out_next;
  end
  assign mod_out = mod_out_reg;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_idle_gated: assert property (
    sym_start && !fifo_pop |=> mod_out.bit_value == $past(idle_modulator_bit))
    else $error("idle bit not presented while gated");
  a_idle_inactive: assert property (
    sym_start && state_reg != RUN_S |=> mod_out.sym_strobe
      && mod_out.bit_value == $past(idle_modulator_bit))
    else $error("modulator fed data while input inactive");
  a_start_load: assert property (
    state_reg == IDLE_S && stb_rise |=> state_reg == START_S
      && cnt_reg == $past(tx_data_delay_reg.start_delay)
         || $past(serial_mode && !clock_master))
    else $error("start delay not loaded on strobe rise");
  a_ext_clock: assert property (
    state_reg == IDLE_S && stb_rise && serial_mode && !clock_master
      |=> cnt_reg == 9'h000 ##1 state_reg == RUN_S)
    else $error("start delay used with external bit clock");
  a_count_down: assert property (
    (state_reg == START_S || state_reg == RESUME_S) && tick
      && cnt_reg != 9'h000 |=> cnt_reg == $past(cnt_reg) - 9'h001)
    else $error("delay counter did not step");
  a_fall_drain: assert property (
    state_reg == RUN_S && stb_fall |=> state_reg == DRAIN_S)
    else $error("strobe fall did not stop data");
  a_drain_resume: assert property (
    state_reg == DRAIN_S && sym_end && !ramp_control_mode |=>
      state_reg == RESUME_S
      && cnt_reg == $past(tx_data_delay_reg.resume_delay))
    else $error("resume delay not started at symbol end");
  a_ramp_rise: assert property (
    state_reg == HOLD_S && stb_rise |=> state_reg == RESUME_S
      && cnt_reg == $past(tx_data_delay_reg.resume_delay))
    else $error("ramp resume not timed from strobe rise");
  a_resume_done: assert property (
    state_reg == RESUME_S && cnt_reg == 9'h000 |=> state_reg == RUN_S)
    else $error("data flow not restarted after resume delay");
  c_start_run: cover property (state_reg == START_S ##1 state_reg == RUN_S);
  c_drain: cover property (state_reg == DRAIN_S ##1 state_reg == RESUME_S);
  c_ramp: cover property (state_reg == HOLD_S ##1 state_reg == RESUME_S);
  c_full: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

/* File: hdl/tx_delay_pkg.sv */
// Function
// - after a timeslot ends, finish current symbol, then send idle bit until resume delay ends
// - resume timing starts at the first symbol end after strobe falls
// - in ramp control mode, resume delay runs from strobe rise, then data restarts
// - start delay, nine bits in eighth symbols, from first strobe rise; resets zero
// - idle bit goes to the modulator until the start delay has elapsed
// - serial mode: start delay applies only when this device drives the bit clock
// - idle bit feeds the modulator whenever its data input is inactive
package tx_delay_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [5:0]  DELAY_REG_ADDR   = 6'h36;
  localparam int          REG_WIDTH        = 18;
  localparam int          START_LSB        = 0;
  localparam int          RESUME_LSB       = 9;
  localparam int          DELAY_WIDTH      = 9;
  localparam logic [17:0] DELAY_REG_RESET  = 18'h00000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int SYMBOL_TIME_NS = 3692;
  localparam int EIGHTHS        = 8;
  // least time: round up to whole clock cycles
  localparam int EIGHTH_CYCLES  =
    (SYMBOL_TIME_NS + EIGHTHS * CLK_PERIOD_NS - 1) / (EIGHTHS * CLK_PERIOD_NS);
  localparam int FIFO_DEPTH     = 16;

  typedef struct packed {
    logic [8:0] resume_delay;
    logic [8:0] start_delay;
  } delay_cfg_t;

  typedef struct packed {
    logic bit_value;
    logic sym_strobe;
  } mod_out_t;

endpackage

/* File: bench/bb_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// baseband controller: link clock, serial bits, transmit strobe
// ------------------------------------------------------------
module bb_ctrl_model
(
  input  wire logic serial_data_ready,
  output logic      serial_bit_clock = 1'b0,
  output logic      serial_data = 1'b0,
  output logic      serial_data_en = 1'b0,
  output logic      transmit_strobe = 1'b0
);
  logic run_clk = 1'b0;

  // link clock stands still outside frames; odd phase against clk
  initial
  begin
    #37;
    forever
    begin
      #80;
      if (run_clk)
        serial_bit_clock = ~serial_bit_clock;
    end
  end

  // hold bit and enable until an edge samples ready high
  task automatic send_bit(input logic b, output logic ok);
    int n;
    n = 0;
    @(posedge serial_bit_clock);
    serial_data    <= b;
    serial_data_en <= 1'b1;
    do
    begin
      @(posedge serial_bit_clock);
      n++;
    end
    while (serial_data_ready !== 1'b1 && n < 20);
    ok = (serial_data_ready === 1'b1);
    serial_data_en <= 1'b0;
    serial_data    <= ~b;  // released line must not look stale
  endtask

  task automatic set_strobe(input logic v);
    transmit_strobe <= v;
  endtask
endmodule

`default_nettype wire

/* File: bench/tx_modulator_data_delay_test.sv */
`timescale 1ns/100ps
`default_nettype none

module tx_modulator_data_delay_test;
  import tx_delay_pkg::*;
  localparam int TICK = 4;
  localparam int SYM  = 8 * TICK;
  logic        clk = 1'b0;
  logic        rstn, reg_wr_en, idle_bit, ramp, smode, cmaster, started;
  logic [5:0]  reg_addr;
  logic [17:0] reg_wr_data;
  wire         sbc, sd, sd_en, sd_ready, strobe;
  wire [17:0]  reg_rd_data;
  mod_out_t    mod_out;
  int          seed = 2, n_fail = 0, total_checks = 0, cyc = 0, last_sym;
  int          idle_until, data_from;
  logic        q[$];

  tx_modulator_data_delay #(.TICK_CYCLES(TICK)) dut
  (
    .clk(clk), .rstn(rstn), .serial_bit_clock(sbc), .serial_data(sd),
    .serial_data_en(sd_en), .serial_data_ready(sd_ready),
    .transmit_strobe(strobe), .idle_modulator_bit(idle_bit),
    .ramp_control_mode(ramp), .serial_mode(smode), .clock_master(cmaster),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .mod_out(mod_out)
  );

  bb_ctrl_model bb
  (
    .serial_data_ready(sd_ready), .serial_bit_clock(sbc), .serial_data(sd),
    .serial_data_en(sd_en), .transmit_strobe(strobe)
  );

  // ------------------------------------------------------------
  // clock, cycle count, checks
  // ------------------------------------------------------------
  initial
  begin
    forever
      #2.5 clk = ~clk;
  end

  always @(posedge clk)
    cyc <= cyc + 1;

  task automatic chk(input string what, input logic [17:0] e,
                     input logic [17:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // symbol monitor: idle before the window, data in order after it;
  // between the two the first non-idle bit marks the start
  always @(negedge clk)
  begin
    if (rstn && mod_out.sym_strobe === 1'b1)
    begin
      if (last_sym > 0)
        chk("symbol period", 18'(SYM), 18'(cyc - last_sym));
      last_sym = cyc;
      if (!started && q.size() > 0 && cyc >= idle_until &&
          (cyc >= data_from || mod_out.bit_value !== idle_bit))
        started = 1'b1;
      if (started)
        chk("bit_value", q.size() ? q.pop_front() : idle_bit,
            mod_out.bit_value);
      else if (cyc < idle_until)
        chk("bit_value", idle_bit, mod_out.bit_value);
    end
  end

  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  task automatic reg_wr(input logic [5:0] a, input logic [17:0] d);
    @(posedge clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clk);
    reg_wr_en   <= 1'b0;
  endtask

  task automatic reg_chk(input logic [5:0] a, input logic [17:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(negedge clk);
    chk("reg_rd_data", e, reg_rd_data);
  endtask

  // first bit is the inverse of idle so the start shows
  task automatic push(input int n);
    logic b, ok;
    bb.run_clk = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      b = (i == 0) ? ~idle_bit : 1'($random(seed));
      bb.send_bit(b, ok);
      if (!ok)
      begin
        n_fail++;
        test_done();
      end
      q.push_back(b);
    end
  endtask

  task automatic wait_empty;
    for (int n = 0; n < 3000 && q.size() > 0; n++)
      @(posedge clk);
    chk("bits left", 0, 18'(q.size()));
    // a drain that never finishes ends the whole simulation here
    if (q.size() > 0)
      test_done();
    repeat (2 * SYM) @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // one run: reset, registers, fill, start delay, drain, resume
  // ------------------------------------------------------------
  task automatic run(input logic sm, input logic cm, input logic rm);
    logic [8:0] d, r;
    int         t;
    bb.set_strobe(1'b0);
    bb.run_clk = 1'b1;
    rstn      <= 1'b0;
    smode     <= sm;
    cmaster   <= cm;
    ramp      <= rm;
    idle_bit  <= 1'($random(seed));
    started    = 1'b0;
    last_sym   = 0;
    idle_until = 1 << 30;
    data_from  = 1 << 30;
    q.delete();
    repeat (120) @(posedge clk);
    rstn <= 1'b1;
    d = 9'(64 + ($random(seed) & 63));
    r = 9'(96 + ($random(seed) & 31));
    reg_chk(6'h36, 18'h00000);
    reg_wr(6'h35, 18'($random(seed)));
    reg_chk(6'h35, 18'h00000);
    reg_chk(6'h36, 18'h00000);
    reg_wr(6'h36, {r, d});
    reg_chk(6'h36, {r, d});
    push(16);
    repeat (4) @(posedge sbc);
    chk("serial_data_ready", 0, 18'(sd_ready));
    bb.run_clk = 1'b0;
    @(posedge clk);
    bb.set_strobe(1'b1);
    idle_until = cyc + ((sm && !cm) ? 0 : d * TICK);
    data_from  = idle_until + 48;
    wait_empty();
    bb.set_strobe(1'b0);
    t = cyc;
    repeat (8) @(posedge clk);
    started    = 1'b0;
    idle_until = (rm ? t + 400 : t) + r * TICK;
    data_from  = idle_until + 80;
    push(4);
    bb.run_clk = 1'b0;
    while (cyc < t + 400)
      @(posedge clk);
    bb.set_strobe(1'b1);
    wait_empty();
    $display("run serial %0d master %0d ramp %0d done", sm, cm, rm);
  endtask

  initial
  begin
    rstn        = 1'b0;
    reg_wr_en   = 1'b0;
    reg_addr    = 6'h00;
    reg_wr_data = 18'h00000;
    idle_bit    = 1'b0;
    ramp        = 1'b0;
    smode       = 1'b0;
    cmaster     = 1'b0;
    run(1'b0, 1'b0, 1'b0);
    run(1'b1, 1'b1, 1'b1);
    run(1'b1, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1'b1);
    test_done();
  end

  // hang guard
  initial
  begin
    #400000;
    n_fail++;
    test_done();
  end
endmodule

`default_nettype wire
